//--- verilog/tdv_validator.sv
// What this block does
// - forward adaption beyond plus or minus 1e9 base_resolution gives code 18
// - code 18 unless forward cutoff plus forward adaption exceeds target range
// - linear axis: code 18 unless forward changeover plus adaption below working range
// - reverse adaption beyond plus or minus 1000000 base_resolution gives code 19
// - code 19 unless reverse cutoff plus reverse adaption exceeds target range
// - linear axis: code 19 unless reverse changeover plus adaption below working range
// - entering or deleting the target set being processed gives code 20
// - target list with no target sets gives code 21
// - target set number already used on another axis gives code 22
// - deleting a data_set that is absent gives code 250
// - PLC entry or deletion without PLC mode gives code 251
// - re-entering a data_set still locked by teach-in gives code 252
// - programming_device_source request without its mode gives code 253
// - entry only in completed axis state, else code 254
// - replacing an already stored target list gives code 254
// - deletion only in completed axis state, else code 255
// - failed list entry stores nothing and keeps earlier content
// - failed list entry reports number of first target set being entered
//
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
module tdv_validator
  import tdv_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input tdv_pkg::tdv_axis_stat_t [2:0] axis_stat,
  output logic irq
);
  import tdv_pkg::*;

  typedef enum logic {ST_IDLE, ST_CHECK} tdv_state_t;

  tdv_state_t state_reg;
  tdv_kind_t kind;
  tdv_axis_stat_t ax;
  tdv_adapt_flags_t fwd_flags, rev_flags;
  logic wr_fire, go, chk, done_reg, from_pg, is_enter, is_set, fwd_bad, rev_bad;
  logic [1:0] mode_reg, irq_mask_reg, irq_stat_reg, irq_stat_next, axis_num, axis_idx, rd_resp;
  logic [3:0] wstrb_reg, ctrl_reg;
  logic [7:0] awaddr_reg, result_code_reg, result_num_reg, err_next, set_num, list_cnt;
  logic [31:0] wdata_reg, num_reg, rd_data;
  logic [31:0] par_reg [PAR_COUNT];
  logic [255:0][1:0] owner_mem;
  logic [255:0] list_mem;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] val,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = val[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge_strb

  // write channel: address and data taken in either order, response after both
  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      awaddr_reg <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      awaddr_reg <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_wready <= 1'b1;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awaddr_reg[1:0] != 2'h0 || awaddr_reg > OFS_MODE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // register writes
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RST;
      num_reg <= NUM_RST;
      mode_reg <= MODE_RST;
      irq_mask_reg <= IRQ_MASK_RST;
      for (int i = 0; i < PAR_COUNT; i++) begin
        par_reg[i] <= 32'h00000000;
      end
    end else if (wr_fire && awaddr_reg[1:0] == 2'h0) begin
      if (awaddr_reg == OFS_CTRL) begin
        if (wstrb_reg[0]) begin
          ctrl_reg <= wdata_reg[3:0];
        end
      end else if (awaddr_reg == OFS_NUM) begin
        num_reg <= merge_strb(num_reg, wdata_reg, wstrb_reg);
      end else if (awaddr_reg >= OFS_PAR_FIRST && awaddr_reg <= OFS_PAR_LAST) begin
        par_reg[3'(awaddr_reg[5:2] - 4'h2)] <= merge_strb(par_reg[3'(awaddr_reg[5:2] - 4'h2)],
                                                           wdata_reg, wstrb_reg);
      end else if (awaddr_reg == OFS_IRQ_MASK) begin
        if (wstrb_reg[0]) begin
          irq_mask_reg <= wdata_reg[1:0];
        end
      end else if (awaddr_reg == OFS_MODE) begin
        if (wstrb_reg[0]) begin
          mode_reg <= wdata_reg[1:0];
        end
      end
    end
  end

  // a go while a request is still being checked is ignored
  assign go = wr_fire && awaddr_reg == OFS_CTRL && wstrb_reg[0] && wdata_reg[CTRL_GO_BIT]
              && state_reg == ST_IDLE;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (go) begin
            state_reg <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // request decode
  assign chk = state_reg == ST_CHECK;
  assign kind = tdv_kind_t'(ctrl_reg[CTRL_KIND_LSB +: 2]);
  assign from_pg = ctrl_reg[CTRL_SRC_BIT];
  assign set_num = num_reg[NUM_SET_LSB +: 8];
  assign axis_num = num_reg[NUM_AXIS_LSB +: 2];
  assign axis_idx = (axis_num == 2'h0) ? 2'h0 : 2'(axis_num - 2'h1);
  assign list_cnt = num_reg[NUM_CNT_LSB +: 8];
  assign is_enter = kind == KIND_ENTER_SET || kind == KIND_ENTER_LIST;
  assign is_set = kind == KIND_ENTER_SET || kind == KIND_DEL_SET;
  assign ax = axis_stat[axis_idx];

  tdv_adapt_check #(.LIMIT(FWD_ADAPT_LIMIT)) u_fwd_check (
    .adapt(par_reg[PAR_FWD_ADAPT]),
    .cutoff(par_reg[PAR_FWD_CUT]),
    .changeover(par_reg[PAR_FWD_CHG]),
    .tgt_range(par_reg[PAR_TGT_RANGE]),
    .work_range(par_reg[PAR_WORK_RANGE]),
    .linear(ctrl_reg[CTRL_LIN_BIT]),
    .flags(fwd_flags)
  );

  tdv_adapt_check #(.LIMIT(REV_ADAPT_LIMIT)) u_rev_check (
    .adapt(par_reg[PAR_REV_ADAPT]),
    .cutoff(par_reg[PAR_REV_CUT]),
    .changeover(par_reg[PAR_REV_CHG]),
    .tgt_range(par_reg[PAR_TGT_RANGE]),
    .work_range(par_reg[PAR_WORK_RANGE]),
    .linear(ctrl_reg[CTRL_LIN_BIT]),
    .flags(rev_flags)
  );

  assign fwd_bad = is_enter && |fwd_flags;
  assign rev_bad = is_enter && |rev_flags;

  always_comb begin
    err_next = ERR_NONE;
    if (fwd_bad) begin
      err_next = ERR_FWD_ADAPT;
    end else if (rev_bad) begin
      err_next = ERR_REV_ADAPT;
    end else if (is_set && ax.active_valid && ax.active_num == set_num) begin
      err_next = ERR_SET_ACTIVE;
    end else if (kind == KIND_ENTER_LIST && list_cnt == 8'h00) begin
      err_next = ERR_LIST_EMPTY;
    end else if (kind == KIND_ENTER_SET && owner_mem[set_num] != 2'h0 && owner_mem[set_num] != axis_num) begin
      err_next = ERR_OTHER_AXIS;
    end else if ((kind == KIND_DEL_SET && owner_mem[set_num] != axis_num)
                 || (kind == KIND_DEL_LIST && !list_mem[set_num])) begin
      err_next = ERR_ABSENT;
    end else if (!from_pg && !mode_reg[MODE_PLC_BIT]) begin
      err_next = ERR_PLC_MODE;
    end else if (is_enter && ax.teach_valid && ax.teach_num == set_num) begin
      err_next = ERR_TEACH;
    end else if (from_pg && !mode_reg[MODE_PG_BIT]) begin
      err_next = ERR_PG_MODE;
    end else if (is_enter && (!ax.completed || (kind == KIND_ENTER_LIST && list_mem[set_num]))) begin
      err_next = ERR_NO_CHANGE;
    end else if (!is_enter && !ax.completed) begin
      err_next = ERR_NO_DELETE;
    end
  end

  // result and status
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      result_code_reg <= ERR_NONE;
      result_num_reg <= 8'h00;
      done_reg <= 1'b0;
    end else if (go) begin
      done_reg <= 1'b0;
    end else if (chk) begin
      result_code_reg <= err_next;
      // first set number of a list
      result_num_reg <= (kind == KIND_ENTER_LIST) ? num_reg[NUM_FIRST_LSB +: 8] : set_num;
      done_reg <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      owner_mem <= '0;
      list_mem <= '0;
    end else if (chk && err_next == ERR_NONE) begin
      case (kind)
        KIND_ENTER_SET: owner_mem[set_num] <= axis_num;
        KIND_DEL_SET: owner_mem[set_num] <= 2'h0;
        KIND_ENTER_LIST: list_mem[set_num] <= 1'b1;
        KIND_DEL_LIST: list_mem[set_num] <= 1'b0;
        default: list_mem <= list_mem;
      endcase
    end
  end

  // sticky events, write one to clear, a new event wins over its clear
  always_comb begin
    irq_stat_next = irq_stat_reg;
    if (wr_fire && awaddr_reg == OFS_IRQ_STAT && wstrb_reg[0]) begin
      irq_stat_next = irq_stat_next & ~wdata_reg[1:0];
    end
    if (chk) begin
      irq_stat_next[IRQ_ACC_BIT] = irq_stat_next[IRQ_ACC_BIT] | (err_next == ERR_NONE);
      irq_stat_next[IRQ_REJ_BIT] = irq_stat_next[IRQ_REJ_BIT] | (err_next != ERR_NONE);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_stat_reg <= 2'h0;
      irq <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq <= |(irq_stat_next & irq_mask_reg);
    end
  end

  // read channel
  always_comb begin
    rd_data = 32'h00000000;
    rd_resp = RESP_OKAY;
    if (s_axi_araddr[1:0] != 2'h0) begin
      rd_resp = RESP_SLVERR;
    end else if (s_axi_araddr == OFS_CTRL) begin
      rd_data = {28'h0000000, ctrl_reg};
    end else if (s_axi_araddr == OFS_NUM) begin
      rd_data = num_reg;
    end else if (s_axi_araddr >= OFS_PAR_FIRST && s_axi_araddr <= OFS_PAR_LAST) begin
      rd_data = par_reg[3'(s_axi_araddr[5:2] - 4'h2)];
    end else if (s_axi_araddr == OFS_RESULT) begin
      rd_data = {14'h0000, state_reg == ST_CHECK, done_reg, result_num_reg, result_code_reg};
    end else if (s_axi_araddr == OFS_IRQ_STAT) begin
      rd_data = {30'h00000000, irq_stat_reg};
    end else if (s_axi_araddr == OFS_IRQ_MASK) begin
      rd_data = {30'h00000000, irq_mask_reg};
    end else if (s_axi_araddr == OFS_MODE) begin
      rd_data = {30'h00000000, mode_reg};
    end else begin
      rd_resp = RESP_SLVERR;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_resp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  fwd_range_a: assert property (chk && is_enter && fwd_flags.range_bad |=> result_code_reg == ERR_FWD_ADAPT)
    else $error("forward adaption range not flagged");
  fwd_cut_a: assert property (chk && is_enter && fwd_flags.cut_bad |=> result_code_reg == 8'h12)
    else $error("forward cutoff sum not flagged");
  fwd_chg_a: assert property (chk && is_enter && fwd_flags.chg_bad |=> result_code_reg == 8'h12)
    else $error("forward changeover sum not flagged");
  rev_adapt_a: assert property (chk && is_enter && !fwd_bad && |rev_flags |=> result_code_reg == 8'h13)
    else $error("reverse adaption not flagged");
  set_active_a: assert property (chk && is_set && ax.active_valid && ax.active_num == set_num
    && !fwd_bad && !rev_bad |=> result_code_reg == ERR_SET_ACTIVE)
    else $error("active set not refused");
  list_empty_a: assert property (chk && kind == KIND_ENTER_LIST && list_cnt == 8'h00
    && !fwd_bad && !rev_bad |=> result_code_reg == ERR_LIST_EMPTY)
    else $error("empty list not refused");
  plc_mode_a: assert property (chk && !from_pg && !mode_reg[MODE_PLC_BIT] |=> result_code_reg != ERR_NONE)
    else $error("request accepted outside PLC mode");
  pg_mode_a: assert property (chk && from_pg && !mode_reg[MODE_PG_BIT] |=> result_code_reg != ERR_NONE)
    else $error("request accepted outside programming device mode");
  state_lock_a: assert property (chk && !ax.completed |=> result_code_reg != ERR_NONE && done_reg)
    else $error("request accepted while axis busy");
  list_keep_a: assert property (chk && err_next != ERR_NONE |=> $stable(list_mem) && $stable(owner_mem))
    else $error("stored content changed on failure");
  first_num_a: assert property (chk && kind == KIND_ENTER_LIST |=> result_num_reg == $past(num_reg[31:24]))
    else $error("first set number not reported");
  single_code_a: assert property (chk && fwd_bad && rev_bad |=> result_code_reg == 8'h12)
    else $error("lower code not chosen");

  set_ok_c: cover property (chk && kind == KIND_ENTER_SET && err_next == ERR_NONE);
  list_fail_c: cover property (chk && kind == KIND_ENTER_LIST && err_next != ERR_NONE);
  del_ok_c: cover property (chk && kind == KIND_DEL_SET && err_next == ERR_NONE);
  irq_c: cover property ($rose(irq));

endmodule : tdv_validator

//--- verilog/tdv_pkg.sv
package tdv_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_NUM = 8'h04;
  localparam logic [7:0] OFS_PAR_FIRST = 8'h08;
  localparam logic [7:0] OFS_PAR_LAST = 8'h24;
  localparam logic [7:0] OFS_RESULT = 8'h28;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h2C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h30;
  localparam logic [7:0] OFS_MODE = 8'h34;

  // parameter word indices, offset (OFS_PAR_FIRST + 4 * index)
  localparam int PAR_FWD_ADAPT = 0;
  localparam int PAR_REV_ADAPT = 1;
  localparam int PAR_FWD_CUT = 2;
  localparam int PAR_FWD_CHG = 3;
  localparam int PAR_REV_CUT = 4;
  localparam int PAR_REV_CHG = 5;
  localparam int PAR_TGT_RANGE = 6;
  localparam int PAR_WORK_RANGE = 7;
  localparam int PAR_COUNT = 8;

  // field positions
  localparam int CTRL_KIND_LSB = 0;
  localparam int CTRL_SRC_BIT = 2;
  localparam int CTRL_LIN_BIT = 3;
  localparam int CTRL_GO_BIT = 4;
  localparam int NUM_SET_LSB = 0;
  localparam int NUM_AXIS_LSB = 8;
  localparam int NUM_CNT_LSB = 16;
  localparam int NUM_FIRST_LSB = 24;
  localparam int RES_NUM_LSB = 8;
  localparam int RES_DONE_BIT = 16;
  localparam int RES_BUSY_BIT = 17;
  localparam int IRQ_ACC_BIT = 0;
  localparam int IRQ_REJ_BIT = 1;
  localparam int MODE_PLC_BIT = 0;
  localparam int MODE_PG_BIT = 1;

  // reset values
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [31:0] NUM_RST = 32'h00000100;
  localparam logic [1:0] MODE_RST = 2'h1;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;

  // adaption magnitude limits in base_resolution units
  localparam logic [31:0] FWD_ADAPT_LIMIT = 32'h3B9ACA00;
  localparam logic [31:0] REV_ADAPT_LIMIT = 32'h000F4240;

  // data_set error codes
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_FWD_ADAPT = 8'h12;
  localparam logic [7:0] ERR_REV_ADAPT = 8'h13;
  localparam logic [7:0] ERR_SET_ACTIVE = 8'h14;
  localparam logic [7:0] ERR_LIST_EMPTY = 8'h15;
  localparam logic [7:0] ERR_OTHER_AXIS = 8'h16;
  localparam logic [7:0] ERR_ABSENT = 8'hFA;
  localparam logic [7:0] ERR_PLC_MODE = 8'hFB;
  localparam logic [7:0] ERR_TEACH = 8'hFC;
  localparam logic [7:0] ERR_PG_MODE = 8'hFD;
  localparam logic [7:0] ERR_NO_CHANGE = 8'hFE;
  localparam logic [7:0] ERR_NO_DELETE = 8'hFF;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    KIND_ENTER_SET,
    KIND_ENTER_LIST,
    KIND_DEL_SET,
    KIND_DEL_LIST
  } tdv_kind_t;

  // per-axis state supplied by the positioning core
  typedef struct packed {
    logic completed;
    logic active_valid;
    logic [7:0] active_num;
    logic teach_valid;
    logic [7:0] teach_num;
  } tdv_axis_stat_t;

  typedef struct packed {
    logic range_bad;
    logic cut_bad;
    logic chg_bad;
  } tdv_adapt_flags_t;

endpackage : tdv_pkg

//--- verilog/tdv_adapt_check.sv
`timescale 1ns/100ps
module tdv_adapt_check
  import tdv_pkg::*;
#(
  parameter logic [31:0] LIMIT = FWD_ADAPT_LIMIT
) (
  input wire logic [31:0] adapt,
  input wire logic [31:0] cutoff,
  input wire logic [31:0] changeover,
  input wire logic [31:0] tgt_range,
  input wire logic [31:0] work_range,
  input wire logic linear,
  output tdv_pkg::tdv_adapt_flags_t flags
);
  logic signed [33:0] a_ext;
  logic signed [33:0] lim_ext;
  logic signed [33:0] cut_sum;
  logic signed [33:0] chg_sum;

  assign a_ext = {{2{adapt[31]}}, adapt};
  assign lim_ext = {2'h0, LIMIT};
  assign cut_sum = {{2{cutoff[31]}}, cutoff} + a_ext;
  assign chg_sum = {{2{changeover[31]}}, changeover} + a_ext;

  // magnitude bound, then the two sum relations
  assign flags.range_bad = (a_ext > lim_ext) || (a_ext < -lim_ext);
  assign flags.cut_bad = !(cut_sum > $signed({{2{tgt_range[31]}}, tgt_range}));
  assign flags.chg_bad = linear && !(chg_sum < $signed({{2{work_range[31]}}, work_range}));

endmodule : tdv_adapt_check

//--- test/tdv_core_model.sv
`timescale 1ns/100ps
module tdv_core_model
  import tdv_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [2:0] moving,
  input wire logic [7:0] act_num,
  input wire logic [7:0] teach_num,
  output tdv_pkg::tdv_axis_stat_t [2:0] axis_stat
);
  // axis 1 alone carries an active or teach-locked set; zero means none
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 3; i++) begin
      axis_stat[i].completed <= !rst_n || !moving[i];
      axis_stat[i].active_valid <= rst_n && i == 0 && act_num != 8'h00;
      axis_stat[i].active_num <= act_num;
      axis_stat[i].teach_valid <= rst_n && i == 0 && teach_num != 8'h00;
      axis_stat[i].teach_num <= teach_num;
    end
  end
endmodule : tdv_core_model

//--- test/testbench.sv
`timescale 1ns/100ps
module testbench;
  import tdv_pkg::*;
  logic core_clk, rst_n, awvalid, wvalid, bvalid, bready, arvalid, rvalid, rready;
  logic awready, wready, arready, irq;
  logic [7:0] awaddr, araddr, act_num, teach_num;
  logic [31:0] wdata, rdata, rd_val;
  logic [1:0] bresp, rresp, rd_resp;
  logic [2:0] moving;
  tdv_axis_stat_t [2:0] axis_stat;
  int error_cnt, tests_run, cycles;
  logic [31:0] dflt [PAR_COUNT] = '{0, 0, 10, 20, 10, 20, 5, 100};

  tdv_validator dut (.core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .axis_stat(axis_stat), .irq(irq));
  tdv_core_model core (.core_clk(core_clk), .rst_n(rst_n), .moving(moving), .act_num(act_num),
    .teach_num(teach_num), .axis_stat(axis_stat));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        bready <= 1'b0;
        rd_resp = bresp;
        break;
      end
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        rready <= 1'b0;
        rd_val = rdata;
        rd_resp = rresp;
        break;
      end
    end
  endtask : axi_rd

  // request, wait for done, judge code and reported number
  task automatic run(input logic [7:0] ctrl, input logic [31:0] num, input logic [7:0] code,
                     input logic [7:0] rnum);
    axi_wr(OFS_NUM, num);
    axi_wr(OFS_CTRL, {24'h0, ctrl});
    rd_val = 32'h0;
    while (rd_val[RES_DONE_BIT] !== 1'b1) axi_rd(OFS_RESULT);
    chk("code", 32'(rd_val[7:0]), 32'(code));
    chk("number", 32'(rd_val[15:8]), 32'(rnum));
  endtask : run

  task automatic set_params(input int idx, input logic [31:0] v);
    for (int i = 0; i < PAR_COUNT; i++) axi_wr(OFS_PAR_FIRST + 8'(4 * i), (i == idx) ? v : dflt[i]);
  endtask : set_params

  task automatic s_reset();
    axi_rd(OFS_MODE);
    chk("mode", rd_val, 32'(MODE_RST));
    axi_rd(OFS_NUM);
    chk("num", rd_val, NUM_RST);
    axi_rd(8'h38);
    chk("rd unmapped", 32'(rd_resp), 32'(RESP_SLVERR));
    axi_wr(8'h38, 32'h1);
    chk("wr unmapped", 32'(rd_resp), 32'(RESP_SLVERR));
  endtask : s_reset

  task automatic s_adapt();
    int idx [7] = '{0, 0, 2, 7, 1, 4, 5};
    logic [31:0] val [7];
    logic [7:0] ec [7] = '{ERR_FWD_ADAPT, ERR_FWD_ADAPT, ERR_FWD_ADAPT, ERR_FWD_ADAPT,
                           ERR_REV_ADAPT, ERR_REV_ADAPT, ERR_REV_ADAPT};
    val = '{FWD_ADAPT_LIMIT + 1, -(FWD_ADAPT_LIMIT + 1), 5, 20, REV_ADAPT_LIMIT + 1, 5, 100};
    for (int k = 0; k < 7; k++) begin
      set_params(idx[k], val[k]);
      run(8'h18, 32'h101, ec[k], 8'h01);
    end
    // non-linear axis skips the changeover sums
    set_params(7, 32'h14);
    run(8'h10, 32'h101, ERR_NONE, 8'h01);
    axi_wr(OFS_PAR_FIRST, FWD_ADAPT_LIMIT + 1);
    run(8'h18, 32'h101, ERR_FWD_ADAPT, 8'h01);
    set_params(-1, 32'h0);
    run(8'h18, 32'h101, ERR_NONE, 8'h01);
  endtask : s_adapt

  task automatic s_rules();
    run(8'h18, 32'h201, ERR_OTHER_AXIS, 8'h01);
    act_num <= 8'h01;
    run(8'h1A, 32'h101, ERR_SET_ACTIVE, 8'h01);
    act_num <= 8'h00;
    run(8'h1A, 32'h107, ERR_ABSENT, 8'h07);
    teach_num <= 8'h01;
    run(8'h18, 32'h101, ERR_TEACH, 8'h01);
    teach_num <= 8'h00;
    axi_wr(OFS_MODE, 32'h2);
    run(8'h18, 32'h105, ERR_PLC_MODE, 8'h05);
    run(8'h1C, 32'h105, ERR_NONE, 8'h05);
    axi_wr(OFS_MODE, 32'h1);
    run(8'h1C, 32'h105, ERR_PG_MODE, 8'h05);
    moving <= 3'b001;
    run(8'h18, 32'h106, ERR_NO_CHANGE, 8'h06);
    run(8'h1A, 32'h105, ERR_NO_DELETE, 8'h05);
    moving <= 3'b000;
    // empty list reports first set and leaves nothing
    run(8'h19, 32'h04000108, ERR_LIST_EMPTY, 8'h04);
    run(8'h1B, 32'h04000108, ERR_ABSENT, 8'h08);
    run(8'h19, 32'h04020109, ERR_NONE, 8'h04);
    run(8'h19, 32'h04020109, ERR_NO_CHANGE, 8'h04);
    run(8'h1A, 32'h101, ERR_NONE, 8'h01);
    run(8'h1A, 32'h101, ERR_ABSENT, 8'h01);
  endtask : s_rules

  task automatic s_irq();
    axi_wr(OFS_IRQ_STAT, 32'h3);
    axi_wr(OFS_IRQ_MASK, 32'h2);
    run(8'h1A, 32'h107, ERR_ABSENT, 8'h07);
    chk("irq on reject", 32'(irq), 32'h1);
    axi_wr(OFS_IRQ_STAT, 32'h2);
    axi_rd(OFS_IRQ_STAT);
    chk("status cleared", rd_val, 32'h0);
    chk("irq cleared", 32'(irq), 32'h0);
    run(8'h18, 32'h102, ERR_NONE, 8'h02);
    chk("irq masked", 32'(irq), 32'h0);
    axi_rd(OFS_IRQ_STAT);
    chk("status accept", rd_val, 32'h1);
  endtask : s_irq

  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  initial begin
    forever begin
      @(posedge core_clk);
      cycles++;
      if (cycles == 30000) begin
        error_cnt++;
        tally_and_finish();
      end
    end
  end

  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    {moving, act_num, teach_num} = '0;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    s_reset();
    s_adapt();
    s_rules();
    s_irq();
    tally_and_finish();
  end
endmodule : testbench
